// *** design/uvr_delay_timer.sv ***
// Delay timer counting a power-of-two number of time units
`timescale 1ns/1ps
module uvr_delay_timer #(
  parameter int UNIT_W = uvr_pkg::UVR_UNIT_W // Width of time unit count
) (
  input wire logic ref_clk_in, // System clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic start_in, // Start or restart the delay
  input wire logic [2:0] code_in, // Delay code, 2^code units
  input wire logic [UNIT_W-1:0] unit_cycles_in, // Time unit in clock cycles
  output logic busy_out, // Delay running
  output logic done_out // One-cycle pulse at expiry
);
  import uvr_pkg::*;

  if (UNIT_W < 2) begin : g_chk
    $error("uvr_delay_timer: UNIT_W too small");
  end

  logic busy_r; // Timer running
  logic done_r; // Expiry pulse
  logic [UNIT_W-1:0] unit_r; // Latched unit length, never zero
  logic [UNIT_W-1:0] unit_cnt_r; // Cycles within the current unit
  logic [UVR_UNITS_W-1:0] left_r; // Units still to run
  logic [UNIT_W-1:0] unit_eff; // Unit length, zero read as one
  // A zero unit would wrap to a 2^UNIT_W-cycle count, so it is stretched to one cycle
  assign unit_eff = (unit_cycles_in == '0) ? {{(UNIT_W-1){1'b0}}, 1'b1} : unit_cycles_in;

  // Unit length latched at start so a mid-run change cannot stretch a delay
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      unit_r <= {{(UNIT_W-1){1'b0}}, 1'b1};
      unit_cnt_r <= '0;
      left_r <= '0;
    end else if (start_in) begin
      busy_r <= 1'b1;
      done_r <= 1'b0;
      unit_r <= unit_eff;
      unit_cnt_r <= '0;
      left_r <= uvr_units(code_in); // RULE_11
    end else begin
      done_r <= 1'b0;
      if (busy_r) begin
        if (unit_cnt_r == unit_r - 1'b1) begin
          unit_cnt_r <= '0;
          left_r <= left_r - 1'b1;
          // Last unit ends the delay
          if (left_r == 8'h01) begin
            busy_r <= 1'b0;
            done_r <= 1'b1; // RULE_10
          end
        end else begin
          unit_cnt_r <= unit_cnt_r + 1'b1;
        end
      end
    end
  end

  assign busy_out = busy_r;
  assign done_out = done_r;

  // Helper: elapsed cycles and expected total, read only by the check below
  logic [UVR_UNITS_W+UNIT_W-1:0] elapsed_r;
  logic [UVR_UNITS_W+UNIT_W-1:0] total_r;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      elapsed_r <= '0;
      total_r <= '0;
    end else if (start_in) begin
      elapsed_r <= '0;
      total_r <= {{UNIT_W{1'b0}}, uvr_units(code_in)} * {{UVR_UNITS_W{1'b0}}, unit_eff};
    end else if (busy_r) begin
      elapsed_r <= elapsed_r + 1'b1;
    end
  end

  property p_span;
    @(posedge ref_clk_in) disable iff (!rst_n_in) done_out |-> elapsed_r == total_r;
  endproperty
  a_span: assert property (p_span) else $error("delay length wrong"); // RULE_10
endmodule // uvr_delay_timer

// *** design/uvr_fault_response.sv ***
// Output under-voltage fault detection, reaction and retry control
`timescale 1ns/1ps
module uvr_fault_response #(
  parameter int UNIT_W = uvr_pkg::UVR_UNIT_W // Width of time unit count
) (
  input wire logic ref_clk_in, // 125 MHz clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic [7:0] cmd_code_in, // Command code of access
  input wire logic wr_en_in, // One-cycle write strobe
  input wire logic [15:0] wr_data_in, // Write data, bytes in low bits
  output logic [15:0] rd_data_out, // Registered read data
  input wire logic [15:0] vout_meas_in, // Measured output voltage
  input wire logic [UNIT_W-1:0] unit_cycles_in, // Time unit for this fault
  input wire logic op_on_in, // Output commanded on (pin and command)
  input wire logic bias_ok_in, // Bias power present, asynchronous
  input wire logic other_fault_in, // Another fault shut the unit down
  input wire logic fault_bit_clear_in, // Clear this fault bit, pulse
  input wire logic clear_faults_in, // Clear all faults, pulse
  output logic output_enable_out, // Power stage enable
  output logic uv_fault_status_out, // Sticky under-voltage fault bit
  output logic host_alert_out, // Pulse when the fault bit sets
  output logic retrying_out // Retry sequence in progress
);
  import uvr_pkg::*;

  if (UNIT_W < 2 || UNIT_W > 24) begin : g_chk
    $error("uvr_fault_response: UNIT_W out of range");
  end

  logic [15:0] threshold_r; // Trip threshold
  logic [7:0] reaction_r; // Reaction configuration
  logic [15:0] rd_data_r; // Read data
  logic bias_s1_r; // Bias synchroniser, first stage
  logic bias_s2_r; // Bias synchroniser, second stage
  logic op_on_d_r; // Previous on command, for edge detect
  uvr_state_t state_r; // Fault handling state
  logic [2:0] attempts_r; // Restart attempts made
  logic start_r; // Timer start request
  logic out_en_r; // Output enable
  logic status_r; // Sticky fault bit
  logic alert_r; // Alert pulse
  logic timer_done; // Timer expired
  logic done_ok; // Expiry not from a stale run

  // Field decode
  logic [1:0] react;
  logic [2:0] retry_lim;
  logic [2:0] delay_code;
  assign react = reaction_r[UVR_REACT_HI:UVR_REACT_LO];
  assign retry_lim = reaction_r[UVR_RETRY_HI:UVR_RETRY_LO];
  assign delay_code = reaction_r[UVR_DELAY_HI:UVR_DELAY_LO];

  // Fault condition and the events that steer the machine
  logic fault_now;
  logic on_rise;
  logic clear_evt;
  logic stop_evt;
  logic fault_set;
  assign fault_now = vout_meas_in < threshold_r; // RULE_13
  assign on_rise = op_on_in & ~op_on_d_r;
  // Off-then-on, bias loss and explicit clears all drop a latched fault
  assign clear_evt = fault_bit_clear_in | clear_faults_in | on_rise | ~bias_s2_r; // RULE_06
  assign stop_evt = ~op_on_in | other_fault_in; // RULE_12
  assign fault_set = (state_r == UVR_RUN) && fault_now && op_on_in && bias_s2_r; // RULE_13
  assign done_ok = timer_done & ~start_r;

  // Register writes
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      threshold_r <= UVR_THRESHOLD_RST;
      reaction_r <= UVR_REACTION_RST;
    end else if (wr_en_in) begin
      if (cmd_code_in == UVR_CMD_THRESHOLD) begin
        threshold_r <= wr_data_in; // RULE_01
      end
      if (cmd_code_in == UVR_CMD_REACTION) begin
        reaction_r <= wr_data_in[7:0];
      end
    end
  end

  // Read data, unknown codes read zero
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rd_data_r <= 16'h0000;
    end else begin
      case (cmd_code_in)
        UVR_CMD_THRESHOLD: rd_data_r <= threshold_r; // RULE_01
        UVR_CMD_REACTION: rd_data_r <= {8'h00, reaction_r};
        default: rd_data_r <= 16'h0000;
      endcase
    end
  end

  // Bias is a pin level; two flops before use
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      bias_s1_r <= 1'b0;
      bias_s2_r <= 1'b0;
      op_on_d_r <= 1'b1; // Idle high, so no false on-edge after reset
    end else begin
      bias_s1_r <= bias_ok_in;
      bias_s2_r <= bias_s1_r;
      op_on_d_r <= op_on_in;
    end
  end

  // Reaction and retry sequencing
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_r <= UVR_RUN;
      attempts_r <= 3'h0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (clear_evt) begin
        state_r <= UVR_RUN; // RULE_06
        attempts_r <= 3'h0;
      end else begin
        case (state_r)
          UVR_RUN: begin
            if (fault_set) begin
              case (react)
                UVR_REACT_DELAYED: begin
                  state_r <= UVR_DELAY; // RULE_03
                  start_r <= 1'b1;
                end
                UVR_REACT_SHUTDOWN: begin
                  // Output drops now; retry setting decides what follows
                  if (retry_lim == UVR_RETRY_NONE) begin
                    state_r <= UVR_LATCHED; // RULE_07
                  end else begin
                    state_r <= UVR_OFF_WAIT; // RULE_04
                    start_r <= 1'b1;
                  end
                end
                UVR_REACT_HOLD: state_r <= UVR_HOLD; // RULE_05
                default: state_r <= UVR_RUN; // RULE_02
              endcase
            end
          end
          UVR_DELAY: begin
            // Fault gone early: back to running, with the sticky fault bit still set
            if (!fault_now) begin
              state_r <= UVR_RUN;
            end else if (done_ok) begin
              if (retry_lim == UVR_RETRY_NONE) begin
                state_r <= UVR_LATCHED; // RULE_07
              end else begin
                state_r <= UVR_OFF_WAIT; // RULE_03
                start_r <= 1'b1;
              end
            end
          end
          UVR_OFF_WAIT: begin
            if (stop_evt) begin
              state_r <= UVR_LATCHED; // RULE_12
            end else if (done_ok) begin
              state_r <= UVR_RESTART; // RULE_10
              attempts_r <= 3'h1;
              start_r <= 1'b1;
            end
          end
          UVR_RESTART: begin
            if (stop_evt) begin
              state_r <= UVR_LATCHED; // RULE_12
            end else if (done_ok) begin
              if (!fault_now) begin
                state_r <= UVR_RUN;
                attempts_r <= 3'h0;
              end else if (retry_lim == UVR_RETRY_ALWAYS) begin
                start_r <= 1'b1; // RULE_09
              end else if (attempts_r < retry_lim) begin
                attempts_r <= attempts_r + 3'h1; // RULE_08
                start_r <= 1'b1; // RULE_10
              end else begin
                state_r <= UVR_LATCHED; // RULE_08
              end
            end
          end
          UVR_HOLD: begin
            if (!fault_now) begin
              state_r <= UVR_RUN; // RULE_05
            end
          end
          UVR_LATCHED: state_r <= UVR_LATCHED; // RULE_07
          default: state_r <= UVR_RUN;
        endcase
      end
    end
  end

  // Output drive follows state one cycle later; gated by command and bias
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      out_en_r <= 1'b0;
    end else begin
      out_en_r <= op_on_in & bias_s2_r & ~other_fault_in &
        ((state_r == UVR_RUN) | (state_r == UVR_DELAY) | (state_r == UVR_RESTART)); // RULE_04
    end
  end

  // Sticky fault bit; a new fault in the clearing cycle wins
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      status_r <= 1'b0;
      alert_r <= 1'b0;
    end else begin
      alert_r <= fault_set & ~status_r;
      if (fault_set) begin
        status_r <= 1'b1; // RULE_13
      end else if (clear_evt) begin
        status_r <= 1'b0; // RULE_06
      end
    end
  end

  uvr_delay_timer #(
    .UNIT_W(UNIT_W)
  ) u_timer (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(start_r),
    .code_in(delay_code),
    .unit_cycles_in(unit_cycles_in),
    .busy_out(),
    .done_out(timer_done)
  );

  assign rd_data_out = rd_data_r;
  assign output_enable_out = out_en_r;
  assign uv_fault_status_out = status_r;
  assign host_alert_out = alert_r;
  assign retrying_out = (state_r == UVR_OFF_WAIT) | (state_r == UVR_RESTART);

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_trip(logic [1:0] code);
    fault_set && !clear_evt && react == code;
  endsequence

  property p_thr_wr;
    wr_en_in && cmd_code_in == UVR_CMD_THRESHOLD |=> ##1 rd_data_out == $past(wr_data_in, 2) ||
      $past(cmd_code_in) != UVR_CMD_THRESHOLD;
  endproperty
  a_thr_wr: assert property (p_thr_wr) else $error("threshold write lost"); // RULE_01
  property p_ignore;
    s_trip(UVR_REACT_IGNORE) |=> state_r == UVR_RUN;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored fault changed state"); // RULE_02
  property p_delay;
    s_trip(UVR_REACT_DELAYED) |=> state_r == UVR_DELAY && start_r;
  endproperty
  a_delay: assert property (p_delay) else $error("delayed reaction missing"); // RULE_03
  property p_shut;
    s_trip(UVR_REACT_SHUTDOWN) ##1 !clear_evt |=> !output_enable_out;
  endproperty
  a_shut: assert property (p_shut) else $error("output not disabled"); // RULE_04
  property p_hold;
    state_r == UVR_HOLD && !fault_now && !clear_evt |=> state_r == UVR_RUN;
  endproperty
  a_hold: assert property (p_hold) else $error("hold did not resume"); // RULE_05
  property p_clear;
    clear_evt && !fault_set |=> state_r == UVR_RUN && !uv_fault_status_out;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not release"); // RULE_06
  property p_noretry;
    s_trip(UVR_REACT_SHUTDOWN) ##0 retry_lim == UVR_RETRY_NONE |=> state_r == UVR_LATCHED;
  endproperty
  a_noretry: assert property (p_noretry) else $error("restart with zero retries"); // RULE_07
  property p_limit;
    state_r == UVR_RESTART && retry_lim != UVR_RETRY_ALWAYS |-> attempts_r <= retry_lim;
  endproperty
  a_limit: assert property (p_limit) else $error("too many restarts"); // RULE_08
  property p_always;
    state_r == UVR_RESTART && done_ok && fault_now && !stop_evt && !clear_evt &&
      retry_lim == UVR_RETRY_ALWAYS |=> state_r == UVR_RESTART && start_r;
  endproperty
  a_always: assert property (p_always) else $error("continuous retry stopped"); // RULE_09
  property p_stop;
    retrying_out && stop_evt && !clear_evt |=> state_r == UVR_LATCHED ##1 !output_enable_out;
  endproperty
  a_stop: assert property (p_stop) else $error("retry not stopped"); // RULE_12
  property p_status;
    fault_set |=> uv_fault_status_out;
  endproperty
  a_status: assert property (p_status) else $error("fault bit not set"); // RULE_13
endmodule // uvr_fault_response

// *** design/uvr_pkg.sv ***
// Constants, state encoding and helpers for the under-voltage fault response block
// Notes on behaviour
// RULE_01 - 16-bit read/write unsigned trip threshold
// RULE_02 - Reaction 00: ignore fault, keep running
// RULE_03 - Reaction 01: run for delay, then retry
// RULE_04 - Reaction 10: disable output now, then retry
// RULE_05 - Reaction 11: off while fault, auto resume
// RULE_06 - Clear events end any latched fault
// RULE_07 - Retry 000: no restart, stay off
// RULE_08 - Retry 1-6: that many restarts, then off
// RULE_09 - Retry 111: restart without limit
// RULE_10 - Attempt starts spaced by delay field units
// RULE_11 - Delay code n means 2^n time units
// RULE_12 - Off command or other fault stops retrying
// RULE_13 - Voltage below threshold declares fault, sets status
package uvr_pkg;
  // Command codes of the two registers
  localparam logic [7:0] UVR_CMD_THRESHOLD = 8'h44;
  localparam logic [7:0] UVR_CMD_REACTION = 8'h45;
  // Reset values
  localparam logic [15:0] UVR_THRESHOLD_RST = 16'h0000;
  localparam logic [7:0] UVR_REACTION_RST = 8'h00;
  // Field positions in the reaction byte
  localparam int UVR_REACT_HI = 7;
  localparam int UVR_REACT_LO = 6;
  localparam int UVR_RETRY_HI = 5;
  localparam int UVR_RETRY_LO = 3;
  localparam int UVR_DELAY_HI = 2;
  localparam int UVR_DELAY_LO = 0;
  // Reaction field codes
  localparam logic [1:0] UVR_REACT_IGNORE = 2'h0;
  localparam logic [1:0] UVR_REACT_DELAYED = 2'h1;
  localparam logic [1:0] UVR_REACT_SHUTDOWN = 2'h2;
  localparam logic [1:0] UVR_REACT_HOLD = 2'h3;
  // Retry field codes
  localparam logic [2:0] UVR_RETRY_NONE = 3'h0;
  localparam logic [2:0] UVR_RETRY_ALWAYS = 3'h7;
  // Default width of the time unit count, in bits
  localparam int UVR_UNIT_W = 16;
  // Widest unit count (code 7 gives 128)
  localparam int UVR_UNITS_W = 8;

  // Fault handling states, Gray along run, delay, off, restart, latched
  typedef enum logic [2:0] {
    UVR_RUN = 3'b000,
    UVR_DELAY = 3'b001,
    UVR_OFF_WAIT = 3'b011,
    UVR_RESTART = 3'b010,
    UVR_LATCHED = 3'b110,
    UVR_HOLD = 3'b100
  } uvr_state_t;

  // Delay code to count of time units
  function automatic logic [UVR_UNITS_W-1:0] uvr_units(input logic [2:0] code);
    return 8'h01 << code; // RULE_11
  endfunction
endpackage

// *** testbench/uvr_fault_response_test.sv ***
// Self-checking bench for the under-voltage fault response block
`timescale 1ns/1ps
module uvr_fault_response_test;
  import uvr_pkg::*;
  localparam logic [15:0] THR = 16'h1000; // Trip level for fault tests
  localparam int UNIT = 3; // Time unit in cycles
  typedef struct {logic [15:0] exp; logic [15:0] mask;} uvr_note_t; // Expected result
  logic ref_clk_in, rst_n_in, wr_en, rd_vld, fb_clr, clr_all, probe, len_chk;
  logic op_on, bias_ok, other_fault, enable, status, alert, retrying, status_d;
  logic [7:0] cmd_code;
  logic [15:0] wr_data, rd_data, vout, unit_cycles;
  logic [31:0] rnd; // Random state
  uvr_note_t notes[$]; // Results still due
  int mismatches, n_checks, run_len, base_len, k;

  uvr_host_model i_uvr_host_model (.ref_clk_in(ref_clk_in), .cmd_code_out(cmd_code),
    .wr_en_out(wr_en), .wr_data_out(wr_data), .fault_bit_clear_out(fb_clr),
    .clear_faults_out(clr_all), .rd_vld_out(rd_vld));
  uvr_fault_response i_uvr_fault_response (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .cmd_code_in(cmd_code), .wr_en_in(wr_en), .wr_data_in(wr_data), .rd_data_out(rd_data),
    .vout_meas_in(vout), .unit_cycles_in(unit_cycles), .op_on_in(op_on),
    .bias_ok_in(bias_ok), .other_fault_in(other_fault), .fault_bit_clear_in(fb_clr),
    .clear_faults_in(clr_all), .output_enable_out(enable), .uv_fault_status_out(status),
    .host_alert_out(alert), .retrying_out(retrying));

  // Free-running 125 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Verdict and end of run
  task automatic summarize;
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Queue an expected value
  task automatic note(input logic [15:0] exp, input logic [15:0] mask);
    notes.push_back('{exp, mask});
  endtask
  // Single compare point; every mismatch but the hang-guard timeout is counted and reported here
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Compare against the oldest note; an empty queue is a mismatch
  task automatic take(input logic [15:0] seen);
    uvr_note_t n;
    n = '{16'h0001, 16'h0000};
    if (notes.size() != 0) n = notes.pop_front();
    check(seen & n.mask, n.exp);
  endtask
  // Ask the watcher for {retrying, status, enable}
  task automatic look(input logic [2:0] exp, input logic [2:0] mask);
    @(negedge ref_clk_in);
    note({13'h0000, exp}, {13'h0000, mask});
    probe = 1'b1;
    @(negedge ref_clk_in);
    probe = 1'b0;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Random level below the trip threshold
  task automatic fault;
    @(negedge ref_clk_in);
    vout = {4'h0, rnd[11:0]};
    rnd = xs(rnd);
  endtask
  // Good voltage, clear, expect running with status cleared
  task automatic recover(input logic all);
    @(negedge ref_clk_in);
    vout = 16'h2000;
    i_uvr_host_model.clear(all);
    cycles(4);
    look(3'b001, 3'b111);
  endtask
  // Persistent fault under a retry setting until the retries give up
  task automatic episode(input logic [7:0] react, input logic chk, input int diff);
    i_uvr_host_model.write(UVR_CMD_REACTION, {8'h00, react});
    if (chk) note(diff[15:0], 16'hFFFF);
    len_chk = chk;
    fault();
    k = 0;
    while (retrying !== 1'b1 && k < 100) begin
      @(negedge ref_clk_in);
      k++;
    end
    check({15'h0000, retrying}, 16'h0001);
    while (retrying === 1'b1 && k < 5000) begin
      @(negedge ref_clk_in);
      k++;
    end
    check({15'h0000, retrying}, 16'h0000);
    look(3'b010, 3'b111);
    recover(1'b0);
  endtask

  // Watcher: read data, retry run lengths, probes and alert pulses
  always @(posedge ref_clk_in) begin
    if (retrying === 1'b1) run_len++;
    else if (run_len != 0) begin
      if (len_chk) take(16'(run_len - base_len));
      base_len = run_len;
      run_len = 0;
    end
    if (rd_vld) take(rd_data);
    if (probe) take({13'h0000, retrying, status, enable});
    // Host notice must pulse exactly where the fault bit sets
    if (alert === 1'b1 || (status === 1'b1 && status_d !== 1'b1)) begin
      check({15'h0000, alert}, {15'h0000, status & ~status_d});
    end
    status_d = status;
  end

  // Hang guard
  initial begin
    #400000;
    mismatches++;
    summarize();
  end

  // Main sequence
  initial begin
    {rst_n_in, probe, len_chk, other_fault} = 4'h0;
    {op_on, bias_ok} = 2'b11;
    vout = 16'h2000;
    unit_cycles = 16'(UNIT);
    rnd = 32'h00000028;
    {mismatches, n_checks, run_len, base_len} = {4{32'h00000000}};
    cycles(20);
    rst_n_in = 1'b1;
    cycles(5);
    note(UVR_THRESHOLD_RST, 16'hFFFF);
    i_uvr_host_model.read(UVR_CMD_THRESHOLD);
    note({8'h00, UVR_REACTION_RST}, 16'hFFFF);
    i_uvr_host_model.read(UVR_CMD_REACTION);
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      i_uvr_host_model.write(UVR_CMD_THRESHOLD, rnd[15:0]);
      i_uvr_host_model.write(UVR_CMD_REACTION, rnd[31:16]);
      i_uvr_host_model.write(8'h46, rnd[31:16]);
      note(rnd[15:0], 16'hFFFF);
      i_uvr_host_model.read(UVR_CMD_THRESHOLD);
      note({8'h00, rnd[23:16]}, 16'hFFFF);
      i_uvr_host_model.read(UVR_CMD_REACTION);
      note(16'h0000, 16'hFFFF);
      i_uvr_host_model.read(8'h46);
    end
    i_uvr_host_model.write(UVR_CMD_THRESHOLD, THR);
    // Level equal to threshold is no fault
    i_uvr_host_model.write(UVR_CMD_REACTION, 8'h80);
    vout = THR;
    // Random settings above may have left a latched or retrying fault
    i_uvr_host_model.clear(1'b1);
    cycles(6);
    look(3'b001, 3'b111);
    // Ignore: keeps running, status still set
    i_uvr_host_model.write(UVR_CMD_REACTION, 8'h3F);
    fault();
    cycles(6);
    look(3'b011, 3'b111);
    recover(1'b1);
    // Off only while the fault lasts
    i_uvr_host_model.write(UVR_CMD_REACTION, 8'hC0);
    fault();
    cycles(4);
    look(3'b010, 3'b111);
    vout = 16'h2000;
    cycles(4);
    look(3'b011, 3'b111);
    recover(1'b0);
    // Shut down, no retry; bias loss clears
    i_uvr_host_model.write(UVR_CMD_REACTION, 8'h80);
    fault();
    cycles(50);
    look(3'b010, 3'b111);
    vout = 16'h2000;
    cycles(10);
    look(3'b010, 3'b111);
    bias_ok = 1'b0;
    cycles(4);
    bias_ok = 1'b1;
    cycles(6);
    look(3'b001, 3'b111);
    // Delayed reaction: short fault rides through, long one shuts down
    i_uvr_host_model.write(UVR_CMD_REACTION, 8'h4A);
    fault();
    cycles(6);
    look(3'b011, 3'b111);
    vout = 16'h2000;
    cycles(10);
    look(3'b011, 3'b111);
    recover(1'b1);
    fault();
    cycles(18);
    look(3'b110, 3'b111);
    cycles(60);
    recover(1'b1);
    // Delayed reaction with no retry ends latched off
    i_uvr_host_model.write(UVR_CMD_REACTION, 8'h42);
    fault();
    cycles(20);
    look(3'b010, 3'b111);
    recover(1'b1);
    // Each extra attempt adds one spacing plus two machine-to-timer hand-off cycles
    for (int r = 1; r < 7; r++) episode(8'h80 | 8'(r << 3), r > 1, UNIT + 2);
    episode(8'h8A, 1'b0, 0);
    episode(8'h92, 1'b1, 4 * UNIT + 2);
    // Endless retry stopped by off command, then by another fault
    len_chk = 1'b0;
    i_uvr_host_model.write(UVR_CMD_REACTION, 8'hB8);
    fault();
    cycles(200);
    look(3'b110, 3'b110);
    op_on = 1'b0;
    cycles(3);
    look(3'b000, 3'b101);
    vout = 16'h2000;
    op_on = 1'b1;
    cycles(6);
    look(3'b001, 3'b111);
    fault();
    cycles(100);
    other_fault = 1'b1;
    cycles(3);
    look(3'b000, 3'b101);
    other_fault = 1'b0;
    recover(1'b0);
    summarize();
  end
endmodule // uvr_fault_response_test

// *** testbench/uvr_host_model.sv ***
// PMBus host model: register writes, reads and fault clears
`timescale 1ns/1ps
module uvr_host_model (
  input wire logic ref_clk_in, // Bench clock
  output logic [7:0] cmd_code_out, // Command code
  output logic wr_en_out, // Write strobe
  output logic [15:0] wr_data_out, // Write data
  output logic fault_bit_clear_out, // Clear this fault bit
  output logic clear_faults_out, // Clear all faults
  output logic rd_vld_out // Read data due this cycle
);
  // Idle bus from time zero
  initial begin
    cmd_code_out = 8'h00;
    wr_en_out = 1'b0;
    wr_data_out = 16'h0000;
    fault_bit_clear_out = 1'b0;
    clear_faults_out = 1'b0;
    rd_vld_out = 1'b0;
  end
  // One-word write; data scrambled after the strobe so stale data is never reused
  task automatic write(input logic [7:0] code, input logic [15:0] data);
    @(negedge ref_clk_in);
    cmd_code_out = code;
    wr_data_out = data;
    wr_en_out = 1'b1;
    @(negedge ref_clk_in);
    wr_en_out = 1'b0;
    wr_data_out = ~data;
  endtask
  // Read: code held two cycles, data flagged in the second
  task automatic read(input logic [7:0] code);
    @(negedge ref_clk_in);
    cmd_code_out = code;
    @(negedge ref_clk_in);
    rd_vld_out = 1'b1;
    @(negedge ref_clk_in);
    rd_vld_out = 1'b0;
  endtask
  // One-cycle clear pulse, all faults or this bit only
  task automatic clear(input logic all);
    @(negedge ref_clk_in);
    clear_faults_out = all;
    fault_bit_clear_out = ~all;
    @(negedge ref_clk_in);
    clear_faults_out = 1'b0;
    fault_bit_clear_out = 1'b0;
  endtask
endmodule // uvr_host_model
